// *** sfs_consts.vh ***
`ifndef SFS_CONSTS_VH
`define SFS_CONSTS_VH
// Register word addresses (byte address / 4)
`define SFS_ADDR_CTRL2 2'h0
`define SFS_ADDR_DATA 2'h1
`define SFS_ADDR_STATUS 2'h2
// Control register two field positions
`define SFS_BIT_FRAMED 15
`define SFS_BIT_DIR 14
`define SFS_BIT_POL 13
`define SFS_BIT_EDGE 1
`define SFS_BIT_ENH 0
`define SFS_CTRL2_RESET 16'h0000
`define SFS_CTRL2_MASK 16'hE003
// Status bit positions
`define SFS_ST_BUSY 0
`define SFS_ST_RXVALID 1
`define SFS_ST_TXFULL 2
`define SFS_ST_TXEMPTY 3
// Frame and clock timing, FIFO sizing
`define SFS_WORD_BITS 16
`define SFS_HALF_DIV 4
`define SFS_FIFO_DEPTH 8
`define SFS_FIFO_AW 3
`endif

// *** sfs_fifo.v ***
`timescale 1ns/1ps
module sfs_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire reset,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output reg [WIDTH-1:0] outData,
  output wire full,
  output wire empty
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtr;
  reg [AW:0] rdPtr;
  reg haveOut;
  wire [AW:0] count;
  wire [AW+1:0] held;
  wire memEmpty;
  wire pop;
  assign count = wrPtr - rdPtr;
  assign memEmpty = (count == {(AW+1){1'b0}});
  // Word in the output register counts toward the depth, so DEPTH words in all
  assign held = {1'b0, count} + {{(AW+1){1'b0}}, haveOut};
  assign full = (held >= DEPTH[AW+1:0]);
  assign inReady = !full;
  assign outValid = haveOut;
  assign empty = memEmpty && !haveOut;
  // Output register refills when empty or being consumed
  assign pop = !memEmpty && (!haveOut || outReady);
  always @(posedge clk) begin
    if (reset) begin
      wrPtr <= {(AW+1){1'b0}};
      rdPtr <= {(AW+1){1'b0}};
      haveOut <= 1'b0;
      outData <= {WIDTH{1'b0}};
    end else begin
      if (inValid && !full) begin
        mem[wrPtr[AW-1:0]] <= inData;
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        outData <= mem[rdPtr[AW-1:0]];
        rdPtr <= rdPtr + 1'b1;
        haveOut <= 1'b1;
      end else if (outReady) begin
        haveOut <= 1'b0;
      end
    end
  end
endmodule // sfs_fifo

// *** sfs_framed_chk.sv ***
`timescale 1ns/1ps
`include "sfs_consts.vh"
module sfs_framed_chk #(
  parameter HALF_DIV = 4
) (
  input wire clk,
  input wire reset,
  input wire [1:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWriteData,
  input wire [31:0] avsReadData,
  input wire avsWaitRequest,
  input wire sckOut,
  input wire sckOe_n,
  input wire slaveSelectOut,
  input wire slaveSelectOe_n
);
  logic [15:0] c;
  wire fm = c[15] && !c[14];
  wire fs = c[15] && c[14];
  wire act = slaveSelectOut == c[13];
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Own copy of control two, so a stuck design register still shows
  always @(posedge clk) begin
    if (reset)
      c <= `SFS_CTRL2_RESET;
    else if (avsWrite && !avsWaitRequest && avsAddress == `SFS_ADDR_CTRL2)
      c <= avsWriteData[15:0] & `SFS_CTRL2_MASK;
  end
  sequence lead8_s;
    (act && !sckOut) [*8] ##5 $rose(sckOut);
  endsequence
  sequence coinc_s;
    ##[1:20] ($rose(sckOut) && (act || $past(act)));
  endsequence
  ctrl_read_a: assert property (avsRead && !avsWaitRequest && avsAddress == 2'h0 |-> avsReadData == {16'h0000, c})
    else $error("control readback differs");
  reset_clear_a: assert property ($fell(reset) |-> avsReadData == 32'h0 && slaveSelectOut && slaveSelectOe_n)
    else $error("outputs not cleared after reset");
  sync_drive_a: assert property (!slaveSelectOe_n |-> fm || $past(fm))
    else $error("select line driven outside framed master");
  slave_clk_a: assert property (fs && $past(fs) |-> sckOe_n)
    else $error("bit clock driven in framed slave");
  sync_pol_a: assert property (fm && c == $past(c, 2) && act |-> ##[0:12] $rose(sckOut))
    else $error("sync active level without a frame");
  sync_lead_a: assert property (fm && !c[1] && $rose(act) && $stable(c) |-> lead8_s)
    else $error("sync does not lead first clock");
  sync_coinc_a: assert property (fm && c[1] && $rose(act) && $stable(c) |-> coinc_s)
    else $error("sync not with first clock");
endmodule // sfs_framed_chk
bind sfs_spi_framed sfs_framed_chk #(.HALF_DIV(HALF_DIV)) u_chk (.clk(clk), .reset(reset), .avsAddress(avsAddress),
  .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
  .avsWaitRequest(avsWaitRequest), .sckOut(sckOut), .sckOe_n(sckOe_n), .slaveSelectOut(slaveSelectOut),
  .slaveSelectOe_n(slaveSelectOe_n));

// *** sfs_peer.sv ***
`timescale 1ns/1ps
module sfs_peer (
  input wire clk,
  input wire sck,
  input wire sdo,
  input wire pol,
  output logic sckP,
  output logic ssP,
  output wire sdi
);
  logic [15:0] tx = 16'h0000;
  logic [15:0] rx = 16'h0000;
  logic [3:0] n = 4'h0;
  logic live = 1'b0;
  logic tog = 1'b0;
  logic sckQ = 1'b0;
  int words = 0;
  // Released line toggles, so a stale bit never passes for data
  assign sdi = live ? tx[15] : tog;
  // Sample on rise, shift on fall, sixteen bits a word
  always @(posedge clk) begin
    sckQ <= sck;
    tog <= !tog;
    if (sck && !sckQ) begin
      rx <= {rx[14:0], sdo};
      n <= n + 4'h1;
      if (n == 4'hF)
        words <= words + 1;
    end
    if (!sck && sckQ) begin
      tx <= {tx[14:0], 1'b0};
      if (n == 4'h0)
        live <= 1'b0;
    end
  end
  task automatic arm(input [15:0] w);
    tx <= w;
    live <= 1'b1;
    n <= 4'h0;
    words <= 0;
  endtask
  // Sync and 320 ns clock only inside the frame
  task automatic frame(input [15:0] w, input e);
    arm(w);
    ssP <= !pol;
    repeat (8) @(posedge clk);
    ssP <= pol;
    if (!e) begin
      repeat (8) @(posedge clk);
      ssP <= !pol;
    end
    for (int b = 0; b < 16; b++) begin
      repeat (4) @(posedge clk);
      sckP <= 1'b1;
      repeat (4) @(posedge clk);
      sckP <= 1'b0;
      ssP <= !pol;
    end
  endtask
  initial begin
    sckP = 1'b0;
    // Idle at the inactive level of the bench's active-high sync
    ssP = 1'b0;
  end
endmodule // sfs_peer

// *** sfs_spi_framed.v ***
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "sfs_consts.vh"
// Function
// R1: Framed enable set turns slave select into frame sync line; clear disables framing.
// R2: Direction one receives sync from peer; zero drives sync out as master.
// R3: Polarity one means active-high sync, zero active-low, both directions.
// R4: Edge select one: sync coincides with first bit clock; zero: precedes it.
// R5: Enhanced buffer bit selects eight-deep FIFO; clear keeps single buffer.
// R6: Control bits twelve to two read zero and ignore writes.
// R7: Reset clears every implemented control bit.
// R8: Software changes sync settings only while the port is idle.
module sfs_spi_framed #(
  parameter HALF_DIV = `SFS_HALF_DIV
) (
  input wire clk,
  input wire reset,
  input wire [1:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWriteData,
  input wire [3:0] avsByteEnable,
  output reg [31:0] avsReadData,
  output wire avsWaitRequest,
  input wire sckIn,
  output reg sckOut,
  output reg sckOe_n,
  input wire slaveSelectIn,
  output reg slaveSelectOut,
  output reg slaveSelectOe_n,
  input wire sdi,
  output reg sdo
);
  localparam ST_IDLE = 4'h1;
  localparam ST_SYNC = 4'h2;
  localparam ST_SHIFT = 4'h4;
  localparam ST_DONE = 4'h8;

  reg [15:0] ctrl2;
  reg [3:0] state;
  reg [15:0] txShift;
  reg [15:0] rxShift;
  reg [15:0] rxHold;
  reg rxValid;
  reg [4:0] bitCnt;
  reg [7:0] divCnt;
  reg ackPending;
  reg [15:0] singleTx;
  reg singleTxValid;
  reg sckMeta, sckSync, sckPrev;
  reg ssMeta, ssSync;
  reg sdiMeta, sdiSync;
  reg syncArmed;

  wire framed = ctrl2[`SFS_BIT_FRAMED];
  wire syncIn = ctrl2[`SFS_BIT_DIR];
  wire syncHigh = ctrl2[`SFS_BIT_POL];
  wire syncCoincide = ctrl2[`SFS_BIT_EDGE];
  wire enhanced = ctrl2[`SFS_BIT_ENH];
  wire busWrite = avsWrite && !ackPending;
  wire busRead = avsRead && !ackPending;
  wire fifoInReady;
  wire fifoOutValid;
  wire [15:0] fifoOutData;
  wire fifoFull;
  wire fifoEmpty;
  wire fifoPush;
  wire txAvail;
  wire [15:0] txWord;
  wire takeTx;
  wire ssActive;
  wire sckRise;
  wire sckFall;
  wire slaveMode;
  wire busy;
  wire txFull;
  wire [15:0] ctrlWrite;

  // Masked before the byte split so every lane keeps its width
  assign ctrlWrite = avsWriteData[15:0] & `SFS_CTRL2_MASK; // [R6]
  // One-cycle wait on every access keeps read data registered
  assign avsWaitRequest = (avsRead || avsWrite) && !ackPending;

  // Ingress choice: FIFO in enhanced mode, single buffer otherwise
  assign fifoPush = busWrite && avsAddress == `SFS_ADDR_DATA && enhanced && avsByteEnable[0]; // [R5]
  assign txAvail = enhanced ? fifoOutValid : singleTxValid; // [R5]
  assign txWord = enhanced ? fifoOutData : singleTx; // [R5]
  assign txFull = enhanced ? fifoFull : singleTxValid; // [R5]
  assign busy = (state != ST_IDLE);

  // Framed slave takes sync and clock from the peer
  assign slaveMode = framed && syncIn; // [R2]
  assign ssActive = syncHigh ? ssSync : !ssSync; // [R3]
  assign sckRise = sckSync && !sckPrev;
  assign sckFall = !sckSync && sckPrev;
  assign takeTx = (state == ST_IDLE) && txAvail && (!slaveMode || (syncArmed && ssActive));

  sfs_fifo #(
    .WIDTH(16),
    .DEPTH(`SFS_FIFO_DEPTH),
    .AW(`SFS_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .inData(avsWriteData[15:0]),
    .outValid(fifoOutValid),
    .outReady(takeTx && enhanced),
    .outData(fifoOutData),
    .full(fifoFull),
    .empty(fifoEmpty)
  );

  // Pin inputs pass two flops before use
  always @(posedge clk) begin
    if (reset) begin
      sckMeta <= 1'b0;
      sckSync <= 1'b0;
      sckPrev <= 1'b0;
      ssMeta <= 1'b0;
      ssSync <= 1'b0;
      sdiMeta <= 1'b0;
      sdiSync <= 1'b0;
    end else begin
      sckMeta <= sckIn;
      sckSync <= sckMeta;
      sckPrev <= sckSync;
      ssMeta <= slaveSelectIn;
      ssSync <= ssMeta;
      sdiMeta <= sdi;
      sdiSync <= sdiMeta;
    end
  end

  // Register file and bus handshake
  always @(posedge clk) begin
    if (reset) begin
      ctrl2 <= `SFS_CTRL2_RESET; // [R7]
      ackPending <= 1'b0;
      avsReadData <= 32'h00000000;
      singleTx <= 16'h0000;
      singleTxValid <= 1'b0;
    end else begin
      ackPending <= (avsRead || avsWrite) && !ackPending;
      if (takeTx && !enhanced)
        singleTxValid <= 1'b0;
      if (busWrite) begin
        case (avsAddress)
          `SFS_ADDR_CTRL2: begin
            // Unimplemented bits are masked off so they stay zero
            if (avsByteEnable[0])
              ctrl2[7:0] <= ctrlWrite[7:0]; // [R6]
            if (avsByteEnable[1])
              ctrl2[15:8] <= ctrlWrite[15:8]; // [R6]
          end
          `SFS_ADDR_DATA: begin
            // Write to a full single buffer is dropped
            if (!enhanced && !singleTxValid && avsByteEnable[0]) begin
              singleTx <= avsWriteData[15:0];
              singleTxValid <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
      if (busRead) begin
        case (avsAddress)
          `SFS_ADDR_CTRL2: avsReadData <= {16'h0000, ctrl2 & `SFS_CTRL2_MASK}; // [R6]
          `SFS_ADDR_DATA: avsReadData <= {16'h0000, rxHold};
          `SFS_ADDR_STATUS: avsReadData <= {28'h0000000, !txAvail, txFull, rxValid, busy};
          default: avsReadData <= 32'h00000000;
        endcase
      end
    end
  end

  // Frame engine; settings are assumed stable while busy
  always @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
      txShift <= 16'h0000;
      rxShift <= 16'h0000;
      rxHold <= 16'h0000;
      rxValid <= 1'b0;
      bitCnt <= 5'h00;
      divCnt <= 8'h00;
      sckOut <= 1'b0;
      sckOe_n <= 1'b1;
      slaveSelectOut <= 1'b1;
      slaveSelectOe_n <= 1'b1;
      sdo <= 1'b0;
      syncArmed <= 1'b0;
    end else begin
      if (busRead && avsAddress == `SFS_ADDR_DATA)
        rxValid <= 1'b0;
      // Master drives clock; framed slave releases it to the peer [R2]
      sckOe_n <= slaveMode;
      // Sync pin driven only in framed master mode [R1] [R2]
      slaveSelectOe_n <= !(framed && !syncIn);
      // Slave arms on inactive sync so one pulse starts one frame
      if (!ssActive)
        syncArmed <= 1'b1;
      else if (takeTx)
        syncArmed <= 1'b0;
      case (state)
        ST_IDLE: begin
          sckOut <= 1'b0;
          slaveSelectOut <= framed ? !syncHigh : 1'b1; // [R3]
          divCnt <= 8'h00;
          if (takeTx) begin
            txShift <= txWord;
            sdo <= txWord[15];
            bitCnt <= 5'h00;
            if (framed && !syncIn) begin
              slaveSelectOut <= syncHigh; // [R1] [R3]
              state <= syncCoincide ? ST_SHIFT : ST_SYNC; // [R4]
            end else begin
              slaveSelectOut <= framed ? !syncHigh : 1'b0;
              state <= ST_SHIFT;
            end
          end
        end
        ST_SYNC: begin
          // Pulse lasts one bit period ahead of the first clock [R4]
          if (divCnt == HALF_DIV * 2 - 1) begin
            divCnt <= 8'h00;
            slaveSelectOut <= !syncHigh; // [R3]
            state <= ST_SHIFT;
          end else
            divCnt <= divCnt + 8'h01;
        end
        ST_SHIFT: begin
          if (slaveMode) begin
            if (sckRise) begin
              rxShift <= {rxShift[14:0], sdiSync};
              bitCnt <= bitCnt + 5'h01;
            end
            if (sckFall) begin
              txShift <= {txShift[14:0], 1'b0};
              sdo <= txShift[14];
              if (bitCnt == `SFS_WORD_BITS)
                state <= ST_DONE;
            end
          end else begin
            if (divCnt == HALF_DIV - 1) begin
              divCnt <= 8'h00;
              sckOut <= !sckOut;
              if (!sckOut) begin
                rxShift <= {rxShift[14:0], sdiSync};
                bitCnt <= bitCnt + 5'h01;
                // Coincident pulse ends on the first rising bit clock edge [R4]
                if (framed && bitCnt == 5'h00)
                  slaveSelectOut <= !syncHigh; // [R3]
              end else begin
                txShift <= {txShift[14:0], 1'b0};
                sdo <= txShift[14];
                if (bitCnt == `SFS_WORD_BITS)
                  state <= ST_DONE;
              end
            end else
              divCnt <= divCnt + 8'h01;
          end
        end
        ST_DONE: begin
          rxHold <= rxShift;
          rxValid <= 1'b1;
          sckOut <= 1'b0;
          slaveSelectOut <= framed ? !syncHigh : 1'b1; // [R1] [R3]
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // sfs_spi_framed

// *** tb.sv ***
`timescale 1ns/1ps
`include "sfs_consts.vh"
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic pol = 1'b1;
  logic [1:0] avsAddress = 2'h0;
  logic [31:0] avsWriteData = 32'h0;
  logic [31:0] q;
  wire [31:0] avsReadData;
  wire avsWaitRequest, sckOut, sckOe_n, slaveSelectOut, slaveSelectOe_n, sdo, sckP, ssP, sdi;
  int err_count = 0;
  int n_checks = 0;
  int lead;
  // Whoever holds its enable low owns the pin
  wire sckPin = sckOe_n ? sckP : sckOut;
  wire ssPin = slaveSelectOe_n ? ssP : slaveSelectOut;
  always #20 clk = !clk;
  sfs_spi_framed DUT (.clk(clk), .reset(reset), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(4'hF), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .sckIn(sckPin), .sckOut(sckOut), .sckOe_n(sckOe_n), .slaveSelectIn(ssPin), .slaveSelectOut(slaveSelectOut),
    .slaveSelectOe_n(slaveSelectOe_n), .sdi(sdi), .sdo(sdo));
  sfs_peer peer (.clk(clk), .sck(sckPin), .sdo(sdo), .pol(pol), .sckP(sckP), .ssP(ssP), .sdi(sdi));
  task automatic chk(input [31:0] got, input [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Hold the request until waitrequest is seen low at a rising edge
  task automatic bus(input [1:0] a, input w, input [15:0] d);
    int t;
    @(posedge clk);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWriteData <= {16'h0000, d};
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (avsWaitRequest !== 1'b0 && t < 50);
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (t >= 50) chk(0, 1);
  endtask
  task automatic poll(input int b, input v);
    int t;
    t = 0;
    do begin
      bus(2'h2, 1'b0, 16'h0000);
      t++;
    end while (q[b] !== v && t < 999);
    if (t >= 999) chk(0, 1);
  endtask
  task automatic complete_run;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    bus(2'h0, 1'b0, 16'h0000);
    chk(q, 32'h0);
    bus(2'h0, 1'b1, 16'hFFFF);
    bus(2'h0, 1'b0, 16'h0000);
    chk(q, `SFS_CTRL2_MASK);
    bus(2'h3, 1'b0, 16'h0000);
    chk(q, 32'h0);
    // Framed master, every polarity and edge setting
    for (int k = 0; k < 4; k++) begin
      pol <= k[0];
      bus(2'h0, 1'b1, {2'h2, k[0], 11'h000, k[1], 1'b0});
      peer.arm(16'h5A3C ^ k[15:0]);
      bus(2'h1, 1'b1, 16'hC3A5 ^ k[15:0]);
      lead = 0;
      while (ssPin !== k[0] && lead < 200) begin
        @(negedge clk);
        lead++;
      end
      chk(ssPin, k[0]);
      lead = 0;
      while (sckPin !== 1'b1 && lead < 50) begin
        @(negedge clk);
        lead++;
      end
      chk(lead, k[1] ? `SFS_HALF_DIV : 3 * `SFS_HALF_DIV);
      poll(`SFS_ST_RXVALID, 1'b1);
      bus(2'h1, 1'b0, 16'h0000);
      chk(q, 16'h5A3C ^ k[15:0]);
      chk(peer.rx, 16'hC3A5 ^ k[15:0]);
    end
    // Framed slave, sync and clock from the peer
    for (int e = 0; e < 2; e++) begin
      pol <= 1'b1;
      bus(2'h0, 1'b1, {14'h3800, e[0], 1'b0});
      bus(2'h1, 1'b1, 16'h9696);
      peer.frame(16'h1E2D, e[0]);
      poll(`SFS_ST_RXVALID, 1'b1);
      bus(2'h1, 1'b0, 16'h0000);
      chk(q, 16'h1E2D);
      chk(peer.rx, 16'h9696);
    end
    // Single buffer fills at two words, the deep one takes nine
    bus(2'h0, 1'b1, 16'h0000);
    bus(2'h1, 1'b1, 16'h1111);
    bus(2'h1, 1'b1, 16'h2222);
    bus(2'h2, 1'b0, 16'h0000);
    chk(q[`SFS_ST_TXFULL], 1'b1);
    poll(`SFS_ST_TXEMPTY, 1'b1);
    poll(`SFS_ST_BUSY, 1'b0);
    bus(2'h0, 1'b1, 16'h0001);
    peer.arm(16'h0000);
    for (int w = 0; w < 10; w++) bus(2'h1, 1'b1, 16'hA000 + w[15:0]);
    bus(2'h2, 1'b0, 16'h0000);
    chk(q[`SFS_ST_TXFULL], 1'b1);
    poll(`SFS_ST_TXEMPTY, 1'b1);
    poll(`SFS_ST_BUSY, 1'b0);
    chk(peer.words, 9);
    complete_run();
  end
endmodule // tb
